// ===== src/fsk_modem_pkg.sv
/*
  Shared constants of the FSK modem output and tone select block:
  register map, field positions, reset values, tone and timing figures.
  Assumes a 100 MHz core clock.
*/
package fsk_modem_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 100_000_000;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TX_DATA_OFFSET = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_HANGUP_BIT = 0;
  localparam int unsigned CTRL_UNCLAMP_BIT = 1;
  localparam logic CTRL_UNCLAMP_RESET = 1'b0;

  // Status register fields
  localparam int unsigned STAT_SEIZE_BIT = 0;
  localparam int unsigned STAT_MODE_BIT = 1;
  localparam int unsigned STAT_CTS_BIT = 2;
  localparam int unsigned STAT_BREAK_BIT = 3;
  localparam int unsigned STAT_EMPTY_BIT = 4;
  localparam int unsigned STAT_FULL_BIT = 5;
  localparam int unsigned STAT_RXDATA_BIT = 6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode levels
  localparam logic MODE_ANSWER = 1'b0;
  localparam logic MODE_ORIGINATE = 1'b1;

  // Transmit tones in Hz
  localparam int unsigned ORIG_MARK_HZ = 1270;
  localparam int unsigned ORIG_SPACE_HZ = 1070;
  localparam int unsigned ANS_MARK_HZ = 2225;
  localparam int unsigned ANS_SPACE_HZ = 2025;

  // Half-period counts of each tone, rounded down
  localparam logic [15:0] ORIG_MARK_HALF = 16'(CLK_HZ / (2 * ORIG_MARK_HZ));
  localparam logic [15:0] ORIG_SPACE_HALF = 16'(CLK_HZ / (2 * ORIG_SPACE_HZ));
  localparam logic [15:0] ANS_MARK_HALF = 16'(CLK_HZ / (2 * ANS_MARK_HZ));
  localparam logic [15:0] ANS_SPACE_HALF = 16'(CLK_HZ / (2 * ANS_SPACE_HZ));

  // Continuous received space that latches break
  localparam int unsigned BREAK_SPACE_MS = 150;
  localparam int unsigned BREAK_SPACE_CYCLES = (CLK_HZ / 1000) * BREAK_SPACE_MS;

  // Least low time of break release, rounded up
  localparam int unsigned BREAK_RELEASE_US = 20;
  localparam logic [11:0] BREAK_RELEASE_CYCLES =
    12'(((CLK_HZ / 1000) * BREAK_RELEASE_US + 999) / 1000);

  // Transmit data rate
  localparam int unsigned TX_BIT_RATE_BPS = 300;
  localparam int unsigned TX_BIT_CYCLES = CLK_HZ / TX_BIT_RATE_BPS;

  // Transmit buffer shape
  localparam int unsigned TX_WORD_WIDTH = 8;
  localparam int unsigned TX_FIFO_DEPTH = 4;

endpackage

// ===== src/tx_word_fifo.sv
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ps
module tx_word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  logic push;
  logic pop;

  assign in_ready_out = (state_reg.count != FULL_COUNT);
  assign out_valid_out = (state_reg.count != '0);
  assign out_data_out = state_reg.mem[state_reg.rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = in_data_in;
      state_next.wr_ptr = PTR_W'(state_reg.wr_ptr + 1'b1);
    end
    if (pop) begin
      state_next.rd_ptr = PTR_W'(state_reg.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      state_next.count = CNT_W'(state_reg.count + 1'b1);
    end else if (pop && !push) begin
      state_next.count = CNT_W'(state_reg.count - 1'b1);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// ===== src/fsk_modem_outputs.sv
/*
  Output side of an originate/answer FSK modem: line seize,
  mode, clear-to-send, receive data and break, tone select
  with a test square, and a buffered transmit path
  fed over AXI4-Lite.
  Assumes synchronous pins and a terminal that keeps
  its side of the handshake.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
// Summary of operation
// - Seize line on (request or ring) and ready
// - Drop line seize when call completes
// - Mode low answering, high originating
// - Self test inverts mode output
// - Clear-to-send low once seized and transmit unclamped
// - Receive data: mark high, space low
// - 150 ms continuous space latches break
// - Break held high until clear-to-send
// - Test square wave at transmit tone
// - Originate: mark 1270 Hz, space 1070 Hz
// - Answer: mark 2225 Hz, space 2025 Hz
// - New tone within 3 us
// - Reset leaves line low and idle
// - Release low 20 us clears break
// - Ring answers, request originates

`timescale 1ns/1ps
module fsk_modem_outputs #(
  parameter int unsigned BREAK_CYCLES = fsk_modem_pkg::BREAK_SPACE_CYCLES,
  parameter int unsigned BIT_CYCLES = fsk_modem_pkg::TX_BIT_CYCLES,
  parameter int unsigned FIFO_DEPTH = fsk_modem_pkg::TX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Terminal and coupler pins
  input wire logic terminal_ready_n_in,
  input wire logic originate_request_n_in,
  input wire logic ring_indication_n_in,
  input wire logic loopback_test_n_in,
  input wire logic break_release_n_in,
  input wire logic rx_demod_in,
  output logic line_seize_out,
  output logic mode_out,
  output logic cts_n_out,
  output logic rx_data_out,
  output logic rx_break_out,
  output logic tone_test_square_out,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int unsigned WORD_W = fsk_modem_pkg::TX_WORD_WIDTH;
  localparam logic [23:0] BREAK_LIMIT = 24'(BREAK_CYCLES - 1);
  localparam logic [19:0] BIT_LIMIT = 20'(BIT_CYCLES - 1);
  localparam logic [3:0] WORD_BITS = 4'(WORD_W);

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic seize;
    logic mode;
    logic mode_pin;
    logic unclamp;
    logic cts_n;
    logic brk;
    logic brk_pin;
    logic rx_data;
    logic square;
    logic [15:0] tone_cnt;
    logic [23:0] space_cnt;
    logic [11:0] rel_cnt;
    tx_state_t tx_state;
    logic [19:0] bit_cnt;
    logic [WORD_W-1:0] shift;
    logic [3:0] bits_left;
    logic cur_bit;
  } modem_state_t;

  modem_state_t state_reg;
  modem_state_t state_next;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic fifo_pop;
  logic tx_level;
  logic [15:0] tone_half;
  logic wr_go;
  logic [31:0] status_word;

  // Mark and space pick their tone from the transmitting mode
  function automatic logic [15:0] pick_tone(input logic mode, input logic mark);
    logic [15:0] half;
    half = fsk_modem_pkg::ANS_SPACE_HALF;
    if (mode == fsk_modem_pkg::MODE_ORIGINATE) begin
      half = mark ? fsk_modem_pkg::ORIG_MARK_HALF : fsk_modem_pkg::ORIG_SPACE_HALF;
    end else begin
      half = mark ? fsk_modem_pkg::ANS_MARK_HALF : fsk_modem_pkg::ANS_SPACE_HALF;
    end
    return half;
  endfunction

  // Clamped or idle transmit sits on a steady mark
  assign tx_level = !state_reg.unclamp || (state_reg.tx_state == TX_IDLE) ||
                    state_reg.cur_bit;
  assign tone_half = pick_tone(state_reg.mode, tx_level);
  assign wr_go = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;
  assign fifo_in_valid = wr_go && (state_reg.aw_addr == fsk_modem_pkg::TX_DATA_OFFSET);
  assign fifo_pop = (state_reg.tx_state == TX_IDLE) && state_reg.seize &&
                    state_reg.unclamp && fifo_out_valid;

  always_comb begin
    status_word = '0;
    status_word[fsk_modem_pkg::STAT_SEIZE_BIT] = state_reg.seize;
    status_word[fsk_modem_pkg::STAT_MODE_BIT] = state_reg.mode;
    status_word[fsk_modem_pkg::STAT_CTS_BIT] = !state_reg.cts_n;
    status_word[fsk_modem_pkg::STAT_BREAK_BIT] = state_reg.brk_pin;
    status_word[fsk_modem_pkg::STAT_EMPTY_BIT] = !fifo_out_valid;
    status_word[fsk_modem_pkg::STAT_FULL_BIT] = !fifo_in_ready;
    status_word[fsk_modem_pkg::STAT_RXDATA_BIT] = state_reg.rx_data;
  end

  always_comb begin
    logic want_call;
    logic hangup;
    want_call = 1'b0;
    hangup = 1'b0;
    state_next = state_reg;

    // Bus: address and data taken independently, one write at a time
    state_next.awready = !state_reg.aw_have && !state_reg.awready && s_axi_awvalid;
    state_next.wready = !state_reg.w_have && !state_reg.wready && s_axi_wvalid;
    if (state_reg.awready && s_axi_awvalid) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (state_reg.wready && s_axi_wvalid) begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      case (state_reg.aw_addr)
        fsk_modem_pkg::CTRL_OFFSET: begin
          if (state_reg.w_strb[0]) begin
            hangup = state_reg.w_data[fsk_modem_pkg::CTRL_HANGUP_BIT];
            state_next.unclamp = state_reg.w_data[fsk_modem_pkg::CTRL_UNCLAMP_BIT];
          end
          state_next.bresp = fsk_modem_pkg::RESP_OKAY;
        end
        fsk_modem_pkg::STATUS_OFFSET: begin
          state_next.bresp = fsk_modem_pkg::RESP_OKAY;
        end
        fsk_modem_pkg::TX_DATA_OFFSET: begin
          state_next.bresp = fsk_modem_pkg::RESP_OKAY;
        end
        default: begin
          state_next.bresp = fsk_modem_pkg::RESP_SLVERR;
        end
      endcase
      // A full buffer holds the response back until a word drains
      if (!fifo_in_valid || fifo_in_ready) begin
        state_next.bvalid = 1'b1;
        state_next.aw_have = 1'b0;
        state_next.w_have = 1'b0;
      end
    end

    // Bus: reads answer the cycle after the address is taken
    state_next.arready = !state_reg.arready && !state_reg.rvalid && s_axi_arvalid;
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (state_reg.arready && s_axi_arvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = fsk_modem_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fsk_modem_pkg::CTRL_OFFSET: begin
          state_next.rdata = '0;
          state_next.rdata[fsk_modem_pkg::CTRL_UNCLAMP_BIT] = state_reg.unclamp;
        end
        fsk_modem_pkg::STATUS_OFFSET: begin
          state_next.rdata = status_word;
        end
        fsk_modem_pkg::TX_DATA_OFFSET: begin
          state_next.rdata = '0;
        end
        default: begin
          state_next.rdata = '0;
          state_next.rresp = fsk_modem_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Line seizure; a live request outweighs a hang-up in the same cycle
    want_call = (!originate_request_n_in || !ring_indication_n_in) &&
                !terminal_ready_n_in;
    if (hangup) begin
      state_next.seize = 1'b0;
      state_next.unclamp = 1'b0;
    end
    if (want_call && !state_reg.seize) begin
      state_next.seize = 1'b1;
      state_next.mode = !ring_indication_n_in ? fsk_modem_pkg::MODE_ANSWER :
                        fsk_modem_pkg::MODE_ORIGINATE;
    end else if (want_call) begin
      state_next.seize = 1'b1;
    end
    state_next.mode_pin = state_next.mode ^ !loopback_test_n_in;
    state_next.cts_n = !(state_next.seize && state_next.unclamp);

    // Receive data follows the demodulator, mark high
    state_next.rx_data = rx_demod_in;

    // Continuous space timer for the break latch
    if (!state_reg.seize || rx_demod_in) begin
      state_next.space_cnt = '0;
    end else if (state_reg.space_cnt != BREAK_LIMIT) begin
      state_next.space_cnt = 24'(state_reg.space_cnt + 1'b1);
    end
    // Release must stay low for the full time to count
    if (break_release_n_in) begin
      state_next.rel_cnt = '0;
    end else if (state_reg.rel_cnt != fsk_modem_pkg::BREAK_RELEASE_CYCLES) begin
      state_next.rel_cnt = 12'(state_reg.rel_cnt + 1'b1);
    end
    if (state_next.rel_cnt == fsk_modem_pkg::BREAK_RELEASE_CYCLES) begin
      state_next.brk = 1'b0;
    end
    if (state_reg.seize && !rx_demod_in && state_reg.space_cnt == BREAK_LIMIT) begin
      state_next.brk = 1'b1;
    end
    state_next.brk_pin = state_next.brk || state_next.cts_n;

    // Transmit serializer, least significant bit first
    case (state_reg.tx_state)
      TX_IDLE: begin
        if (fifo_pop) begin
          state_next.tx_state = TX_SHIFT;
          state_next.shift = fifo_out_data >> 1;
          state_next.cur_bit = fifo_out_data[0];
          state_next.bits_left = 4'(WORD_BITS - 1'b1);
          state_next.bit_cnt = '0;
        end
      end
      TX_SHIFT: begin
        if (state_reg.bit_cnt != BIT_LIMIT) begin
          state_next.bit_cnt = 20'(state_reg.bit_cnt + 1'b1);
        end else begin
          state_next.bit_cnt = '0;
          if (state_reg.bits_left == '0) begin
            state_next.tx_state = TX_IDLE;
          end else begin
            state_next.cur_bit = state_reg.shift[0];
            state_next.shift = state_reg.shift >> 1;
            state_next.bits_left = 4'(state_reg.bits_left - 1'b1);
          end
        end
      end
      default: begin
        state_next.tx_state = TX_IDLE;
      end
    endcase
    if (!state_next.seize || !state_next.unclamp) begin
      state_next.tx_state = TX_IDLE;
    end

    // Tone half-period counter; a shorter new period wraps at once
    if (!state_reg.seize) begin
      state_next.tone_cnt = '0;
      state_next.square = 1'b0;
    end else if (state_reg.tone_cnt >= 16'(tone_half - 1'b1)) begin
      state_next.tone_cnt = '0;
      state_next.square = !state_reg.square;
    end else begin
      state_next.tone_cnt = 16'(state_reg.tone_cnt + 1'b1);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.mode <= fsk_modem_pkg::MODE_ANSWER;
      state_reg.unclamp <= fsk_modem_pkg::CTRL_UNCLAMP_RESET;
      state_reg.cts_n <= 1'b1;
      state_reg.brk_pin <= 1'b1;
      state_reg.rx_data <= 1'b1;
      state_reg.tx_state <= TX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  tx_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) tx_fifo (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(fifo_in_valid),
    .in_data_in(state_reg.w_data[WORD_W-1:0]),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_pop)
  );

  assign line_seize_out = state_reg.seize;
  assign mode_out = state_reg.mode_pin;
  assign cts_n_out = state_reg.cts_n;
  assign rx_data_out = state_reg.rx_data;
  assign rx_break_out = state_reg.brk_pin;
  assign tone_test_square_out = state_reg.square;
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rvalid = state_reg.rvalid;

endmodule

// ===== verif/fsk_modem_outputs_assertions.sv
/*
  Pin-side checks of the FSK modem output block.
  Assumes it is bound into fsk_modem_outputs and sees its ports.
*/
`timescale 1ns/1ps
module fsk_modem_outputs_assertions #(
  parameter int unsigned BREAK_CYCLES = 50
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Watched pins
  input wire logic terminal_ready_n_in,
  input wire logic originate_request_n_in,
  input wire logic ring_indication_n_in,
  input wire logic loopback_test_n_in,
  input wire logic break_release_n_in,
  input wire logic rx_demod_in,
  input wire logic line_seize_out,
  input wire logic mode_out,
  input wire logic cts_n_out,
  input wire logic rx_data_out,
  input wire logic rx_break_out,
  input wire logic tone_test_square_out
);
  typedef struct packed {
    logic [31:0] space;
    logic [15:0] rel;
  } watch_state_t;
  watch_state_t st_reg;
  watch_state_t st_next;

  // Runs of received space while seized and of release held low
  always_comb begin
    st_next = st_reg;
    st_next.space = (line_seize_out && !rx_demod_in) ? st_reg.space + 32'h1 : 32'h0;
    st_next.rel = break_release_n_in ? 16'h0 : st_reg.rel + {15'h0, st_reg.rel != 16'hFFFF};
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking dflt @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_seize_on_call: assert property (
    (!originate_request_n_in || !ring_indication_n_in) && !terminal_ready_n_in |=> line_seize_out)
    else $error("no seize");
  a_seize_stays_idle: assert property (
    !line_seize_out && originate_request_n_in && ring_indication_n_in |=> !line_seize_out)
    else $error("stray seize");
  a_mode_from_call: assert property (
    $rose(line_seize_out) |-> mode_out == ($past(ring_indication_n_in) ^ !$past(loopback_test_n_in)))
    else $error("mode wrong");
  a_selftest_flips: assert property (
    line_seize_out && $changed(loopback_test_n_in) |=> mode_out != $past(mode_out))
    else $error("mode not flipped");
  a_cts_needs_seize: assert property (
    !cts_n_out |-> line_seize_out)
    else $error("cts unseized");
  a_rx_data_path: assert property (
    1'b1 |=> rx_data_out == $past(rx_demod_in))
    else $error("rx data wrong");
  a_break_latches: assert property (
    st_reg.space >= BREAK_CYCLES + 2 |-> rx_break_out)
    else $error("break missed");
  a_break_not_early: assert property (
    !rx_break_out && st_reg.space + 32'd3 < BREAK_CYCLES |=> cts_n_out || !rx_break_out)
    else $error("break early");
  a_cts_clamps_break: assert property (
    cts_n_out |-> rx_break_out)
    else $error("break not clamped");
  a_break_holds: assert property (
    rx_break_out && !cts_n_out && break_release_n_in && $past(break_release_n_in) |=> rx_break_out)
    else $error("break dropped");
  a_release_clears: assert property (
    st_reg.rel > 16'd2005 && rx_demod_in && !cts_n_out |-> ##2 (cts_n_out || !rx_break_out))
    else $error("break not cleared");
  a_square_idle: assert property (
    !line_seize_out [*2] |-> !tone_test_square_out)
    else $error("square idle");
endmodule

bind fsk_modem_outputs fsk_modem_outputs_assertions #(.BREAK_CYCLES(BREAK_CYCLES)) u_chk (.*);

// ===== verif/terminal_coupler_model.sv
/*
  Behavioural terminal and data coupler facing the modem pins.
  Assumes the bench calls its tasks; levels change just after an edge.
*/
`timescale 1ns/1ps
module terminal_coupler_model (
  // Clock
  input wire logic core_clk_in,
  // Pins toward the modem, idle at their pulled-up level
  output logic terminal_ready_n_out = 1'b1,
  output logic originate_request_n_out = 1'b1,
  output logic ring_indication_n_out = 1'b1,
  output logic loopback_test_n_out = 1'b1,
  output logic break_release_n_out = 1'b1,
  output logic rx_demod_out = 1'b1
);
  // Bits: ready, request, ring, self test
  task automatic set_pins(input logic [3:0] p);
    @(posedge core_clk_in);
    terminal_ready_n_out <= p[3];
    originate_request_n_out <= p[2];
    ring_indication_n_out <= p[1];
    loopback_test_n_out <= p[0];
  endtask

  task automatic set_rx(input logic lvl);
    @(posedge core_clk_in);
    rx_demod_out <= lvl;
  endtask

  // Release pin or received data low for a run, then high
  task automatic hold_low(input logic brk, input int cycles);
    @(posedge core_clk_in);
    if (brk) break_release_n_out <= 1'b0;
    else rx_demod_out <= 1'b0;
    repeat (cycles) @(posedge core_clk_in);
    if (brk) break_release_n_out <= 1'b1;
    else rx_demod_out <= 1'b1;
  endtask
endmodule

// ===== verif/fsk_modem_outputs_tb_top.sv
/*
  Self-checking bench of the FSK modem output block.
  Assumes the terminal and coupler model drives the pins.
*/
`timescale 1ns/1ps
module fsk_modem_outputs_tb_top;
  localparam int unsigned BRK = 50;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rdy_n, req_n, ring_n, lb_n, rel_n, rx_demod;
  logic seize, mode, cts_n, rx_data, rx_brk, square;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h0000BDCF;
  int err_total = 0;
  int checked = 0;

  always #5 core_clk_in = ~core_clk_in;

  fsk_modem_outputs #(.BREAK_CYCLES(BRK), .BIT_CYCLES(20), .FIFO_DEPTH(4)) u_fsk_modem_outputs (
    .core_clk_in, .rst_n_in, .terminal_ready_n_in(rdy_n),
    .originate_request_n_in(req_n), .ring_indication_n_in(ring_n), .loopback_test_n_in(lb_n),
    .break_release_n_in(rel_n), .rx_demod_in(rx_demod), .line_seize_out(seize),
    .mode_out(mode), .cts_n_out(cts_n), .rx_data_out(rx_data), .rx_break_out(rx_brk),
    .tone_test_square_out(square), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  terminal_coupler_model u_terminal_coupler_model (
    .core_clk_in, .terminal_ready_n_out(rdy_n), .originate_request_n_out(req_n),
    .ring_indication_n_out(ring_n), .loopback_test_n_out(lb_n),
    .break_release_n_out(rel_n), .rx_demod_out(rx_demod));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [31:0] stat(input logic sz, md, ct, bk, em, fu, rd);
    logic [31:0] v;
    v = 32'h0;
    v[fsk_modem_pkg::STAT_SEIZE_BIT] = sz;
    v[fsk_modem_pkg::STAT_MODE_BIT] = md;
    v[fsk_modem_pkg::STAT_CTS_BIT] = ct;
    v[fsk_modem_pkg::STAT_BREAK_BIT] = bk;
    v[fsk_modem_pkg::STAT_EMPTY_BIT] = em;
    v[fsk_modem_pkg::STAT_FULL_BIT] = fu;
    v[fsk_modem_pkg::STAT_RXDATA_BIT] = rd;
    return v;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    err_total++;
    print_verdict();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 2000);
    r = bresp;
    bready <= 1'b0;
    if (n >= 2000) give_up();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 500);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 500) give_up();
  endtask

  // Cycles from seizure to the first rise of the test square
  task automatic tone_check(input int hz);
    int n;
    int half;
    half = fsk_modem_pkg::CLK_HZ / (2 * hz);
    n = 0;
    while (seize !== 1'b1 && n < 60000) begin
      @(posedge core_clk_in);
      n++;
    end
    n = 0;
    while (square !== 1'b1 && n < 60000) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 60000) give_up();
    check(32'(n > half - 3 && n < half + 3), 32'h1);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    check(32'({seize, cts_n, rx_brk}), 32'h3);
    axi_rd(fsk_modem_pkg::STATUS_OFFSET, d, r);
    check(d, stat(1'b0, fsk_modem_pkg::MODE_ANSWER, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
    axi_rd(8'h0C, d, r);
    check({d[29:0], r}, {30'h0, fsk_modem_pkg::RESP_SLVERR});
    axi_wr(8'h10, 32'h1, r);
    check(32'(r), 32'(fsk_modem_pkg::RESP_SLVERR));
    axi_wr(fsk_modem_pkg::STATUS_OFFSET, 32'hFF, r);
    check(32'(r), 32'(fsk_modem_pkg::RESP_OKAY));
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      u_terminal_coupler_model.set_rx(seed[0]);
    end
    u_terminal_coupler_model.set_rx(1'b1);
    u_terminal_coupler_model.set_pins(4'hB);
    repeat (10) @(posedge core_clk_in);
    check(32'(seize), 32'h0);
    u_terminal_coupler_model.set_pins(4'h3);
    tone_check(1270);
    check(32'(mode), 32'(fsk_modem_pkg::MODE_ORIGINATE));
    u_terminal_coupler_model.set_pins(4'h2);
    repeat (3) @(posedge core_clk_in);
    check(32'(mode), 32'(fsk_modem_pkg::MODE_ANSWER));
    u_terminal_coupler_model.set_pins(4'h3);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      axi_wr(fsk_modem_pkg::TX_DATA_OFFSET, seed, r);
    end
    axi_rd(fsk_modem_pkg::STATUS_OFFSET, d, r);
    check(d, stat(1'b1, fsk_modem_pkg::MODE_ORIGINATE, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1));
    axi_wr(fsk_modem_pkg::CTRL_OFFSET, 32'h2, r);
    axi_wr(fsk_modem_pkg::TX_DATA_OFFSET, 32'h55, r);
    check(32'(r), 32'(fsk_modem_pkg::RESP_OKAY));
    check(32'({cts_n, rx_brk}), 32'h0);
    n = 0;
    do begin
      repeat (20) @(posedge core_clk_in);
      axi_rd(fsk_modem_pkg::STATUS_OFFSET, d, r);
      n++;
    end while (d[fsk_modem_pkg::STAT_EMPTY_BIT] !== 1'b1 && n < 100);
    check(32'(d[fsk_modem_pkg::STAT_EMPTY_BIT]), 32'h1);
    u_terminal_coupler_model.hold_low(1'b0, BRK + 8);
    repeat (2) @(posedge core_clk_in);
    check(32'(rx_brk), 32'h1);
    u_terminal_coupler_model.hold_low(1'b1, 1000);
    repeat (2) @(posedge core_clk_in);
    check(32'(rx_brk), 32'h1);
    u_terminal_coupler_model.hold_low(1'b1, 2010);
    repeat (2) @(posedge core_clk_in);
    check(32'(rx_brk), 32'h0);
    u_terminal_coupler_model.set_pins(4'h7);
    axi_wr(fsk_modem_pkg::CTRL_OFFSET, 32'h1, r);
    repeat (2) @(posedge core_clk_in);
    check(32'({seize, cts_n, rx_brk, square}), 32'h6);
    u_terminal_coupler_model.set_pins(4'h5);
    tone_check(2225);
    check(32'(mode), 32'(fsk_modem_pkg::MODE_ANSWER));
    u_terminal_coupler_model.set_pins(4'h7);
    axi_wr(fsk_modem_pkg::CTRL_OFFSET, 32'h1, r);
    repeat (2) @(posedge core_clk_in);
    check(32'(seize), 32'h0);
    print_verdict();
  end
endmodule
